// file: ivp_consts.svh
`ifndef IVP_CONSTS_SVH
`define IVP_CONSTS_SVH

// Register byte addresses
`define IVP_CTRL_ADDR      12'h000
`define IVP_STATUS_ADDR    12'h004
`define IVP_CONFIG_ADDR    12'h008
`define IVP_PC_ADDR        12'h00c

// Control register fields
`define IVP_VSEL_BIT       1
`define IVP_VCE_BIT        0
`define IVP_CTRL_RESET     8'h00
`define IVP_CTRL_RW_MASK   8'he3

// Config register fields
`define IVP_CFG_BRST_BIT   0
`define IVP_CFG_BSZ_LO     1
`define IVP_CFG_BSZ_HI     2
`define IVP_CFG_APPLK_BIT  3
`define IVP_CFG_BOOTLK_BIT 4
`define IVP_CFG_RESET      32'h0000_0001

// Window length in CPU cycles
`define IVP_WINDOW_CYCLES  3'h4

// Vector table layout, word addresses
`define IVP_RESET_WORD     13'h0000
`define IVP_VEC_FIRST      13'h0002

// Boot section start per size fuse code (16K-byte Flash, word address)
`define IVP_BOOT_START_0   13'h1c00
`define IVP_BOOT_START_1   13'h1e00
`define IVP_BOOT_START_2   13'h1f00
`define IVP_BOOT_START_3   13'h1f80

// AXI responses
`define IVP_RESP_OKAY      2'b00
`define IVP_RESP_SLVERR    2'b10

`endif

// file: ivp_pkg.sv
package ivp_pkg;
   typedef logic [12:0] ivp_waddr_t;
   typedef enum logic [1:0] {
      IVP_SZ_2K,
      IVP_SZ_1K,
      IVP_SZ_512,
      IVP_SZ_256
   } ivp_boot_size_fuses_t;
endpackage

// file: ivp_vec_if.sv
`timescale 1ns/1ps
interface ivp_vec_if;
   logic                 vector_select;
   logic [1:0]           boot_size_fuses;
   logic                 boot_reset_fuse;
   ivp_pkg::ivp_waddr_t  boot_start;
   ivp_pkg::ivp_waddr_t  vec_base;
   ivp_pkg::ivp_waddr_t  reset_addr;

   modport ctrl (output vector_select, output boot_size_fuses, output boot_reset_fuse,
                 input boot_start, input vec_base, input reset_addr);
   modport calc (input vector_select, input boot_size_fuses, input boot_reset_fuse,
                 output boot_start, output vec_base, output reset_addr);
endinterface

// file: ivp_vec_calc.sv
`timescale 1ns/1ps
`include "ivp_consts.svh"
module ivp_vec_calc (
   input  wire logic clk,
   input  wire logic reset,
   ivp_vec_if.calc   vif
);
   ivp_pkg::ivp_waddr_t start_nxt;

   // ----------------------------------------
   // Boot section start from size fuses
   // ----------------------------------------
   always_comb begin
      case (ivp_pkg::ivp_boot_size_fuses_t'(vif.boot_size_fuses))
         ivp_pkg::IVP_SZ_2K:  start_nxt = `IVP_BOOT_START_0;
         ivp_pkg::IVP_SZ_1K:  start_nxt = `IVP_BOOT_START_1;
         ivp_pkg::IVP_SZ_512: start_nxt = `IVP_BOOT_START_2;
         default:             start_nxt = `IVP_BOOT_START_3;
      endcase
   end

   // Registered so all address outputs are flop driven
   always_ff @(posedge clk) begin
      if (reset) begin
         vif.boot_start <= `IVP_BOOT_START_0;
         vif.vec_base   <= `IVP_VEC_FIRST;
         vif.reset_addr <= `IVP_RESET_WORD;
      end else begin
         vif.boot_start <= start_nxt;
         // Relocated table is normal table offset by boot start
         vif.vec_base   <= vif.vector_select ? start_nxt + `IVP_VEC_FIRST
                                             : `IVP_VEC_FIRST;
         // Programmed fuse (0) starts execution in the boot section
         vif.reset_addr <= vif.boot_reset_fuse ? `IVP_RESET_WORD
                                               : start_nxt;
      end
   end
endmodule

// file: ivp_top.sv
`timescale 1ns/1ps
`include "ivp_consts.svh"
module ivp_top (
   input  wire logic        clk,
   input  wire logic        reset,
   // AXI4-Lite slave
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Core side
   input  wire logic        cpu_cycle_en,
   input  wire logic        instr_done,
   input  wire logic        global_int_en,
   input  wire logic        exec_in_boot,
   output logic             int_service_en,
   output logic [12:0]      vector_base,
   output logic [12:0]      reset_address,
   output logic [12:0]      boot_start_addr
);
   ivp_vec_if vif ();

   logic [7:0]  ctrl_r;
   logic [2:0]  win_cnt_r;
   logic        hold_r;
   logic        wait_instr_r;
   logic [31:0] cfg_r;
   logic [12:0] pc_r;
   logic        aw_have_r;
   logic        w_have_r;
   logic [11:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        wr_fire;
   logic        wr_ctrl;
   logic        wr_ok;
   logic        vce_set;
   logic        vsel_write;
   logic        win_open;
   logic        rd_fire;
   logic [31:0] rd_nxt;
   logic [1:0]  rresp_nxt;
   logic        lock_block;

   // ----------------------------------------
   // Write channel capture
   // ----------------------------------------
   // Address and data accepted independently, either order
   always_ff @(posedge clk) begin
      if (reset) begin
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         awaddr_r      <= 12'h000;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         if (s_axi_awvalid && !aw_have_r && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && !w_have_r && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
         end
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
         end
      end
   end

   assign wr_fire    = aw_have_r && w_have_r && !s_axi_bvalid;
   assign wr_ctrl    = wr_fire && (awaddr_r == `IVP_CTRL_ADDR) && wstrb_r[0];
   assign wr_ok      = (awaddr_r == `IVP_CTRL_ADDR) || (awaddr_r == `IVP_STATUS_ADDR)
                       || (awaddr_r == `IVP_CONFIG_ADDR) || (awaddr_r == `IVP_PC_ADDR);
   assign win_open   = ctrl_r[`IVP_VCE_BIT];
   // Enable bit write arms the window
   assign vce_set    = wr_ctrl && wdata_r[`IVP_VCE_BIT];
   // Select write only counts inside the window, with enable written zero
   assign vsel_write = wr_ctrl && win_open && !wdata_r[`IVP_VCE_BIT];

   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `IVP_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? `IVP_RESP_OKAY : `IVP_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Control register and change window
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_r    <= `IVP_CTRL_RESET;
         win_cnt_r <= 3'h0;
      end else begin
         if (wr_ctrl) begin
            // Interrupt enable bits 7:5 plain read/write
            ctrl_r[7:5] <= wdata_r[7:5];
         end
         if (vsel_write) begin
            ctrl_r[`IVP_VSEL_BIT] <= wdata_r[`IVP_VSEL_BIT];
            ctrl_r[`IVP_VCE_BIT]  <= 1'b0;
            win_cnt_r             <= 3'h0;
         end else if (vce_set) begin
            // Rewriting enable restarts the window
            ctrl_r[`IVP_VCE_BIT] <= 1'b1;
            win_cnt_r            <= 3'h0;
         end else if (win_open && cpu_cycle_en) begin
            if (win_cnt_r == `IVP_WINDOW_CYCLES - 3'h1) begin
               ctrl_r[`IVP_VCE_BIT] <= 1'b0;
               win_cnt_r            <= 3'h0;
            end else begin
               win_cnt_r <= win_cnt_r + 3'h1;
            end
         end
      end
   end

   // ----------------------------------------
   // Interrupt blocking
   // ----------------------------------------
   // After a select write, hold off until the next instruction retires
   always_ff @(posedge clk) begin
      if (reset) begin
         wait_instr_r <= 1'b0;
      end else if (vsel_write) begin
         wait_instr_r <= 1'b1;
      end else if (wait_instr_r && instr_done) begin
         wait_instr_r <= 1'b0;
      end
   end

   always_comb begin
      lock_block = 1'b0;
      if (ctrl_r[`IVP_VSEL_BIT] && !cfg_r[`IVP_CFG_APPLK_BIT] && !exec_in_boot) begin
         lock_block = 1'b1;
      end else if (!ctrl_r[`IVP_VSEL_BIT] && !cfg_r[`IVP_CFG_BOOTLK_BIT] && exec_in_boot) begin
         lock_block = 1'b1;
      end
   end

   // Lock bits programmed means zero; global enable only gates, never written
   always_ff @(posedge clk) begin
      if (reset) begin
         hold_r         <= 1'b0;
         int_service_en <= 1'b0;
      end else begin
         hold_r         <= vce_set || win_open || vsel_write || wait_instr_r;
         int_service_en <= global_int_en && !lock_block && !vce_set && !vsel_write
                           && !(win_open && !(cpu_cycle_en
                                && win_cnt_r == `IVP_WINDOW_CYCLES - 3'h1))
                           && !wait_instr_r;
      end
   end

   // ----------------------------------------
   // Fuse configuration and vector outputs
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_r <= `IVP_CFG_RESET;
      end else if (wr_fire && awaddr_r == `IVP_CONFIG_ADDR && wstrb_r[0]) begin
         cfg_r <= {27'h0, wdata_r[4:0]};
      end
   end

   assign vif.vector_select   = ctrl_r[`IVP_VSEL_BIT];
   assign vif.boot_size_fuses = cfg_r[`IVP_CFG_BSZ_HI:`IVP_CFG_BSZ_LO];
   assign vif.boot_reset_fuse = cfg_r[`IVP_CFG_BRST_BIT];

   ivp_vec_calc u_calc (
      .clk   (clk),
      .reset (reset),
      .vif   (vif.calc)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         vector_base     <= `IVP_VEC_FIRST;
         reset_address   <= `IVP_RESET_WORD;
         boot_start_addr <= `IVP_BOOT_START_0;
         pc_r            <= `IVP_RESET_WORD;
      end else begin
         vector_base     <= vif.vec_base;
         reset_address   <= vif.reset_addr;
         boot_start_addr <= vif.boot_start;
         pc_r            <= vif.reset_addr;
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   always_comb begin
      rd_nxt    = 32'h0000_0000;
      rresp_nxt = `IVP_RESP_OKAY;
      if (s_axi_araddr == `IVP_CTRL_ADDR) begin
         rd_nxt = {24'h0, ctrl_r & `IVP_CTRL_RW_MASK};
      end else if (s_axi_araddr == `IVP_STATUS_ADDR) begin
         rd_nxt = {26'h0, win_cnt_r, wait_instr_r, hold_r, int_service_en};
      end else if (s_axi_araddr == `IVP_CONFIG_ADDR) begin
         rd_nxt = cfg_r;
      end else if (s_axi_araddr == `IVP_PC_ADDR) begin
         rd_nxt = {3'h0, vector_base, 3'h0, pc_r};
      end else begin
         rresp_nxt = `IVP_RESP_SLVERR;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `IVP_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_nxt;
            s_axi_rresp  <= rresp_nxt;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// file: ivp_core_model.sv
`timescale 1ns/1ps
// ----
// Core stand-in
// ----
module ivp_core_model (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic slow,
   input  wire logic retire,
   input  wire logic in_boot,
   output logic      cpu_cycle_en,
   output logic      instr_done,
   output logic      global_int_en,
   output logic      exec_in_boot
);
   logic [1:0] phase_r;
   // The core owns its I bit; the block may only read it
   assign global_int_en = 1'b1;
   assign exec_in_boot  = in_boot;
   // Slow mode halves the cycle rate, so the window spans eight clocks
   assign cpu_cycle_en  = slow ? phase_r[0] : 1'b1;
   assign instr_done    = retire && phase_r == 2'h3;
   always_ff @(posedge clk) begin
      if (reset) begin
         phase_r <= 2'h0;
      end else begin
         phase_r <= phase_r + 2'h1;
      end
   end
endmodule

// file: ivp_props.sv
`timescale 1ns/1ps
`include "ivp_consts.svh"
module ivp_props (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        int_service_en,
   input wire logic [12:0] vector_base,
   input wire logic [12:0] reset_address,
   input wire logic [12:0] boot_start_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic wr_hs;
   // Address and data are offered together, so one edge takes both
   assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   sequence s_ce_taken;
      wr_hs && s_axi_awaddr == `IVP_CTRL_ADDR && s_axi_wdata[0];
   endsequence
   sequence s_bad_wr;
      wr_hs && s_axi_awaddr > `IVP_PC_ADDR;
   endsequence
   a_reset_values: assert property ($fell(reset) |-> !int_service_en
      && vector_base == 13'h0002 && boot_start_addr == 13'h1c00) else $error("bad reset state");
   a_block_min: assert property (s_ce_taken |-> ##2 (!int_service_en) [*3])
      else $error("service not blocked after enable");
   a_wresp_bound: assert property (wr_hs |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   a_slverr_code: assert property (s_bad_wr |-> ##[1:3] s_axi_bvalid
      && s_axi_bresp == `IVP_RESP_SLVERR) else $error("unmapped write not refused");
   a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   a_vec_base: assert property ($stable(boot_start_addr) |-> vector_base == 13'h0002
      || vector_base == boot_start_addr + 13'h0002) else $error("vector base off table");
   a_reset_addr: assert property ($stable(boot_start_addr) |-> reset_address == 13'h0
      || reset_address == boot_start_addr) else $error("reset address off table");
   a_boot_table: assert property (boot_start_addr inside {`IVP_BOOT_START_0,
      `IVP_BOOT_START_1, `IVP_BOOT_START_2, `IVP_BOOT_START_3}) else $error("boot start bad");
endmodule
bind ivp_top ivp_props u_props (.*);

// file: testbench.sv
`timescale 1ns/1ps
`include "ivp_consts.svh"
module testbench;
   logic        clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, cpu_cycle_en, instr_done, global_int_en, exec_in_boot;
   logic        int_service_en, slow, retire, in_boot;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, q;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [12:0] vector_base, reset_address, boot_start_addr;
   int          err_total, comparisons, seed, low_run, last_low;

   ivp_top DUT (.*);
   ivp_core_model core (.*);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Length of the last finished stretch with servicing blocked
   always @(posedge clk) begin
      if (int_service_en === 1'b0) begin
         low_run <= low_run + 1;
      end else if (low_run != 0) begin
         last_low <= low_run;
         low_run  <= 0;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      int n;
      n = 0;
      s_axi_awaddr  <= a;
      s_axi_awprot  <= 3'($random(seed));
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 40);
      if (!s_axi_bvalid) err_total++;
      r = s_axi_bresp;
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      n = 0;
      s_axi_araddr  <= a;
      s_axi_arprot  <= 3'($random(seed));
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 40);
      if (!s_axi_rvalid) err_total++;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic wait_int(input logic v);
      int n;
      n = 0;
      while (int_service_en !== v && n < 30) begin
         @(posedge clk);
         n++;
      end
   endtask
   // Enable first, then select with enable clear, inside the window
   task automatic move(input logic sel);
      wr(`IVP_CTRL_ADDR, 32'h1);
      @(posedge clk);
      chk(int_service_en, 1'b0, "blocked on enable");
      wr(`IVP_CTRL_ADDR, {30'h0, sel, 1'b0});
   endtask
   task automatic lock_chk(input logic [31:0] cfg, input logic boot, input logic exp);
      wr(`IVP_CONFIG_ADDR, cfg);
      in_boot <= boot;
      repeat (8) @(posedge clk);
      chk(int_service_en, exp, "lock gating");
   endtask
   function automatic logic [12:0] exp_boot(input logic [1:0] sz);
      case (sz)
         2'h0: return `IVP_BOOT_START_0;
         2'h1: return `IVP_BOOT_START_1;
         2'h2: return `IVP_BOOT_START_2;
         default: return `IVP_BOOT_START_3;
      endcase
   endfunction
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      final_report();
   end
   initial begin
      {reset, slow, retire, in_boot} = 4'h8;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h3;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {seed, err_total, comparisons, low_run, last_low} = {32'd72969, 128'd0};
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(`IVP_CTRL_ADDR);
      chk(d, `IVP_CTRL_RESET, "control reset");
      rd(`IVP_CONFIG_ADDR);
      chk(d, `IVP_CFG_RESET, "config reset");
      rd(`IVP_PC_ADDR);
      chk(d, 32'h0002_0000, "address reset");
      $display("test reset done");
      wr(12'h010, 32'h5a);
      chk(r, `IVP_RESP_SLVERR, "unmapped write");
      rd(12'h010);
      chk({d[29:0], r}, {30'h0, `IVP_RESP_SLVERR}, "unmapped read");
      repeat (4) begin
         q = $random(seed);
         wr(`IVP_CTRL_ADDR, q & 32'hfe);
         rd(`IVP_CTRL_ADDR);
         chk(d, q & 32'he0, "select without enable");
      end
      $display("test bus done");
      for (int i = 0; i < 9; i++) begin
         wr(`IVP_CONFIG_ADDR, 32'h18 | (i % 8));
         repeat (3) @(posedge clk);
         chk(boot_start_addr, exp_boot(2'(i / 2)), "boot start");
         chk(reset_address, i[0] ? 13'h0 : exp_boot(2'(i / 2)), "reset address");
      end
      $display("test fuses done");
      slow <= 1'b1;
      move(1'b1);
      repeat (3) @(posedge clk);
      chk(vector_base, 13'h1c02, "relocated base");
      rd(`IVP_CTRL_ADDR);
      chk(d, 32'h2, "enable cleared");
      chk(int_service_en, 1'b0, "held until retire");
      retire <= 1'b1;
      wait_int(1'b1);
      chk(int_service_en, 1'b1, "released by retire");
      slow <= 1'b0;
      wr(`IVP_CTRL_ADDR, 32'h1);
      wait_int(1'b1);
      repeat (2) @(posedge clk);
      chk(last_low, 4, "block length");
      wr(`IVP_CTRL_ADDR, 32'h0);
      repeat (3) @(posedge clk);
      chk(vector_base, 13'h1c02, "late select ignored");
      $display("test change done");
      lock_chk(32'h10, 1'b0, 1'b0);
      lock_chk(32'h10, 1'b1, 1'b1);
      lock_chk(32'h08, 1'b1, 1'b1);
      slow <= 1'b1;
      move(1'b0);
      lock_chk(32'h08, 1'b1, 1'b0);
      lock_chk(32'h08, 1'b0, 1'b1);
      chk(vector_base, 13'h0002, "base restored");
      $display("test locks done");
      final_report();
   end
endmodule
